/* spt_host.sv */
`timescale 1ns/1ps
module spt_host #(
  parameter BIT = 80
) (
  input wire clk_i,
  input wire txd_i,
  output reg rxd_o
);
  reg [7:0] rxq [$];
  reg [7:0] b;
  integer i;
  initial rxd_o = 1'b1;
  // mid-bit sampling, 8n1 lsb first
  always begin
    @(negedge txd_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge clk_i);
      b[i] = txd_i;
    end
    repeat (BIT) @(posedge clk_i);
    rxq.push_back(b);
  end
  // 7e1 for the addressed protocol, else 8n1
  // the bench drives only this one receiver
  task send(input [7:0] d, input a7);
    reg [9:0] f;
    integer k;
    f = a7 ? {1'b1, ^d[6:0], d[6:0], 1'b0} : {1'b1, d, 1'b0};
    for (k = 0; k < 10; k++) begin
      rxd_o <= f[k];
      repeat (BIT) @(posedge clk_i);
    end
  endtask
endmodule

/* spt_map.vh */
`ifndef SPT_MAP_VH
`define SPT_MAP_VH
// clock and line rates
`define SPT_CLK_HZ 20000000
`define SPT_OVERSAMPLE 16
`define SPT_BAUD_300 300
`define SPT_BAUD_600 600
`define SPT_BAUD_1200 1200
`define SPT_BAUD_2400 2400
`define SPT_BAUD_4800 4800
`define SPT_BAUD_9600 9600
`define SPT_BAUD_19200 19200
`define SPT_BAUD_IDX_RST 3'h5
`define SPT_BAUD_IDX_MAX 3'h6
// port operating modes
`define SPT_MODE_DISABLED 3'h0
`define SPT_MODE_SYNC_MASTER 3'h1
`define SPT_MODE_SYNC_SLAVE 3'h2
`define SPT_MODE_FIELDBUS 3'h3
`define SPT_MODE_TAG_LIST 3'h4
`define SPT_MODE_COPROC 3'h5
`define SPT_MODE_ASCII 3'h6
`define SPT_MODE_RST 3'h0
// characters
`define SPT_CHR_EOF 8'h1a
`define SPT_CHR_PAUSE 8'h13
`define SPT_CHR_RESUME 8'h11
`define SPT_REC_LEN 4'hd
`define SPT_REC_LAST 4'hc
// error report codes
`define SPT_ERR_NONE 16'h0000
`define SPT_ERR_LINE 16'h03c1
// register byte offsets
`define SPT_REG_CTRL 8'h00
`define SPT_REG_MODE 8'h04
`define SPT_REG_BAUD 8'h08
`define SPT_REG_STAT 8'h0c
`define SPT_REG_ERR 8'h10
`define SPT_REG_GROUP 8'h14
`define SPT_REG_UNIT 8'h18
`define SPT_REG_OPT_ADDR 8'h1c
`define SPT_REG_OPT_LIVE 8'h20
// control bits
`define SPT_CTRL_DUMP 0
`define SPT_CTRL_SEND 1
`define SPT_CTRL_RECV 2
`define SPT_CTRL_ACK 3
// frame layout
`define SPT_FRAME_BITS 4'ha
`define SPT_RX_STOP 4'h9
`define SPT_OS_MID 4'h7
`define SPT_OS_LAST 4'hf
`endif

/* spt_serial_port.v */
`timescale 1ns/1ps
// Functional notes
// - file transfer uses 8 data, no parity, 1 stop
// - default 9600 baud, rate selectable by register
// - pause/resume characters honoured during transfers while mode is disabled
// - text dump streams live settings
// - image send streams saved nonvolatile values
// - every sent file ends with end-of-file
// - image ends with end-of-data record before end-of-file
// - receive status shown before host sends
// - received image written to nonvolatile, closed by end-of-file
// - after receive wait ack key, then reset
// - any error report write clears it, except in a cycle with a new line fault
// - group and unit form one shared address
// - address zero-zero answered as broadcast in ascii mode only
// - option address sampled only at card init
// - option version nonzero once card initialised
// - option values shown only in fieldbus mode
// - ascii protocol: 7 data, even parity, 1 stop
// - ascii traffic only in ascii mode
// - baud choices 300 to 19200, default 9600
// - mode codes 0 disabled through 6 ascii
// - line fault records line-error code
`include "spt_map.vh"
module spt_serial_port #(
  parameter CLK_HZ = `SPT_CLK_HZ
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // serial line
  input wire UART_RXD_I,
  output reg UART_TXD_O,
  // transmit byte source
  input wire [7:0] SRC_DATA_I,
  input wire SRC_VALID_I,
  input wire SRC_LAST_I,
  output reg SRC_READY_O,
  output reg SRC_NVM_O,
  output reg SRC_ACTIVE_O,
  // nonvolatile write port
  input wire NVM_BUSY_I,
  output reg NVM_WE_O,
  output reg [15:0] NVM_ADDR_O,
  output reg [7:0] NVM_DATA_O,
  output reg RESET_REQ_O,
  // ascii protocol side
  input wire [7:0] MSG_GROUP_I,
  input wire [7:0] MSG_UNIT_I,
  input wire MSG_VALID_I,
  output reg ADDR_HIT_O,
  output reg [7:0] RX_DATA_O,
  output reg RX_VALID_O,
  // option card
  input wire OPT_INIT_I,
  input wire [15:0] OPT_VER_I,
  output reg [7:0] OPT_ADDR_O
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SRC = 3'h1;
  localparam ST_REC = 3'h2;
  localparam ST_EOF = 3'h3;
  localparam ST_RECV = 3'h4;
  localparam ST_ACK = 3'h5;

  function [15:0] baud_div;
    input [2:0] idx;
    integer rate;
    integer div;
    begin
      case (idx)
        3'h0: rate = `SPT_BAUD_300;
        3'h1: rate = `SPT_BAUD_600;
        3'h2: rate = `SPT_BAUD_1200;
        3'h3: rate = `SPT_BAUD_2400;
        3'h4: rate = `SPT_BAUD_4800;
        3'h6: rate = `SPT_BAUD_19200;
        default: rate = `SPT_BAUD_9600;
      endcase
      div = CLK_HZ / (rate * `SPT_OVERSAMPLE);
      baud_div = div[15:0];
    end
  endfunction

  // end-of-data record, then line end
  function [7:0] rec_char;
    input [3:0] i;
    begin
      case (i)
        4'h0: rec_char = 8'h3a;
        4'h8: rec_char = 8'h31;
        4'h9: rec_char = 8'h46;
        4'ha: rec_char = 8'h46;
        4'hb: rec_char = 8'h0d;
        4'hc: rec_char = 8'h0a;
        default: rec_char = 8'h30;
      endcase
    end
  endfunction

  function [9:0] frame;
    input [7:0] d;
    input ascii;
    begin
      if (ascii) begin
        frame = {1'b1, ^d[6:0], d[6:0], 1'b0};
      end else begin
        frame = {1'b1, d, 1'b0};
      end
    end
  endfunction

  reg [2:0] mode_q;
  reg [2:0] baud_q;
  reg [15:0] err_q;
  reg [7:0] group_q;
  reg [7:0] unit_q;
  reg [7:0] opt_set_q;
  reg [15:0] opt_ver_q;
  reg [2:0] st_q;
  reg [3:0] rec_q;
  reg paused_q;
  reg rxd_s1_q;
  reg rxd_s2_q;
  reg [15:0] os_cnt_q;
  reg os_tick_q;
  reg tx_busy_q;
  reg [9:0] tx_sh_q;
  reg [3:0] tx_bit_q;
  reg [3:0] tx_os_q;
  reg rx_act_q;
  reg [3:0] rx_bit_q;
  reg [3:0] rx_os_q;
  reg [7:0] rx_sh_q;

  wire ascii_mode = (mode_q == `SPT_MODE_ASCII);
  wire xfer_mode = (mode_q == `SPT_MODE_DISABLED);
  wire fb_mode = (mode_q == `SPT_MODE_FIELDBUS);
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire ctrl_wr = wb_wr & (WB_ADR_I == `SPT_REG_CTRL);
  wire err_wr = wb_req & WB_WE_I & (WB_ADR_I == `SPT_REG_ERR);

  // receiver frame end, evaluated at the stop bit sample
  wire rx_done = rx_act_q & os_tick_q & (rx_os_q == `SPT_OS_LAST) &
    (rx_bit_q == `SPT_RX_STOP);
  wire [7:0] rx_byte = ascii_mode ? {1'b0, rx_sh_q[6:0]} : rx_sh_q;
  wire rx_par_bad = ascii_mode & (^rx_sh_q);
  wire rx_frm_bad = ~rxd_s2_q;
  wire rx_ovr = rx_done & (st_q == ST_RECV) & NVM_BUSY_I;
  wire line_err = rx_done & (rx_par_bad | rx_frm_bad) | rx_ovr;
  wire rx_good = rx_done & ~rx_par_bad & ~rx_frm_bad;

  // transmit load from sequencer
  reg ld;
  reg [7:0] ld_byte;
  always @* begin
    ld = 1'b0;
    ld_byte = `SPT_CHR_EOF;
    if (~tx_busy_q & ~paused_q & ~SRC_READY_O) begin
      case (st_q)
        ST_SRC: begin
          ld = SRC_VALID_I;
          ld_byte = SRC_DATA_I;
        end
        ST_REC: begin
          ld = 1'b1;
          ld_byte = rec_char(rec_q);
        end
        ST_EOF: begin
          ld = 1'b1;
          ld_byte = `SPT_CHR_EOF;
        end
        default: begin
          ld = 1'b0;
        end
      endcase
    end
  end

  // wishbone registers
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      mode_q <= `SPT_MODE_RST;
      baud_q <= `SPT_BAUD_IDX_RST;
      group_q <= 8'h00;
      unit_q <= 8'h00;
      opt_set_q <= 8'h00;
      err_q <= `SPT_ERR_NONE;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (line_err) begin
        err_q <= `SPT_ERR_LINE;
      end else if (err_wr) begin
        err_q <= `SPT_ERR_NONE;
      end
      if (wb_wr) begin
        case (WB_ADR_I)
          `SPT_REG_MODE: begin
            if (WB_DAT_I[2:0] <= `SPT_MODE_ASCII) begin
              mode_q <= WB_DAT_I[2:0];
            end
          end
          `SPT_REG_BAUD: begin
            if (WB_DAT_I[2:0] <= `SPT_BAUD_IDX_MAX) begin
              baud_q <= WB_DAT_I[2:0];
            end
          end
          `SPT_REG_GROUP: group_q <= WB_DAT_I[7:0];
          `SPT_REG_UNIT: unit_q <= WB_DAT_I[7:0];
          `SPT_REG_OPT_ADDR: opt_set_q <= WB_DAT_I[7:0];
          default: begin
          end
        endcase
      end
      if (wb_req & ~WB_WE_I) begin
        case (WB_ADR_I)
          `SPT_REG_MODE: WB_DAT_O <= {29'h0, mode_q};
          `SPT_REG_BAUD: WB_DAT_O <= {29'h0, baud_q};
          `SPT_REG_STAT: WB_DAT_O <= {25'h0, paused_q, tx_busy_q, rx_act_q, 1'b0, st_q};
          `SPT_REG_ERR: WB_DAT_O <= {16'h0, err_q};
          `SPT_REG_GROUP: WB_DAT_O <= {24'h0, group_q};
          `SPT_REG_UNIT: WB_DAT_O <= {24'h0, unit_q};
          `SPT_REG_OPT_ADDR: WB_DAT_O <= {24'h0, opt_set_q};
          `SPT_REG_OPT_LIVE: begin
            if (fb_mode) begin
              WB_DAT_O <= {opt_ver_q, 8'h00, OPT_ADDR_O};
            end
          end
          default: WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  // option card sampling; cleared only by reset (power cycle)
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      OPT_ADDR_O <= 8'h00;
      opt_ver_q <= 16'h0000;
    end else if (OPT_INIT_I) begin
      OPT_ADDR_O <= opt_set_q;
      opt_ver_q <= OPT_VER_I;
    end
  end

  // transfer sequencer
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      st_q <= ST_IDLE;
      rec_q <= 4'h0;
      paused_q <= 1'b0;
      SRC_READY_O <= 1'b0;
      SRC_NVM_O <= 1'b0;
      SRC_ACTIVE_O <= 1'b0;
      NVM_WE_O <= 1'b0;
      NVM_ADDR_O <= 16'h0000;
      NVM_DATA_O <= 8'h00;
      RESET_REQ_O <= 1'b0;
    end else begin
      SRC_READY_O <= 1'b0;
      NVM_WE_O <= 1'b0;
      RESET_REQ_O <= 1'b0;
      if (rx_good & xfer_mode & (st_q != ST_IDLE)) begin
        if (rx_byte == `SPT_CHR_PAUSE) begin
          paused_q <= 1'b1;
        end else if (rx_byte == `SPT_CHR_RESUME) begin
          paused_q <= 1'b0;
        end
      end
      case (st_q)
        ST_IDLE: begin
          paused_q <= 1'b0;
          rec_q <= 4'h0;
          // starts honoured only with the port disabled
          if (ctrl_wr & xfer_mode) begin
            if (WB_DAT_I[`SPT_CTRL_DUMP]) begin
              SRC_NVM_O <= 1'b0;
              SRC_ACTIVE_O <= 1'b1;
              st_q <= ST_SRC;
            end else if (WB_DAT_I[`SPT_CTRL_SEND]) begin
              SRC_NVM_O <= 1'b1;
              SRC_ACTIVE_O <= 1'b1;
              st_q <= ST_SRC;
            end else if (WB_DAT_I[`SPT_CTRL_RECV]) begin
              NVM_ADDR_O <= 16'h0000;
              st_q <= ST_RECV;
            end
          end
        end
        ST_SRC: begin
          if (ld) begin
            SRC_READY_O <= 1'b1;
            if (SRC_LAST_I) begin
              SRC_ACTIVE_O <= 1'b0;
              st_q <= SRC_NVM_O ? ST_REC : ST_EOF;
            end
          end
        end
        ST_REC: begin
          if (ld) begin
            rec_q <= rec_q + 4'h1;
            if (rec_q == `SPT_REC_LAST) begin
              st_q <= ST_EOF;
            end
          end
        end
        ST_EOF: begin
          if (ld) begin
            st_q <= ST_IDLE;
          end
        end
        ST_RECV: begin
          if (rx_good) begin
            if (rx_byte == `SPT_CHR_EOF) begin
              st_q <= ST_ACK;
            end else if (~NVM_BUSY_I) begin
              // overrun byte is dropped, only the error is kept
              NVM_WE_O <= 1'b1;
              NVM_DATA_O <= rx_byte;
            end
          end
          if (NVM_WE_O) begin
            NVM_ADDR_O <= NVM_ADDR_O + 16'h0001;
          end
        end
        ST_ACK: begin
          if (ctrl_wr & WB_DAT_I[`SPT_CTRL_ACK]) begin
            RESET_REQ_O <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // oversample tick, rate from baud register
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      os_cnt_q <= 16'h0000;
      os_tick_q <= 1'b0;
    end else begin
      os_tick_q <= 1'b0;
      if (os_cnt_q >= baud_div(baud_q) - 16'h0001) begin
        os_cnt_q <= 16'h0000;
        os_tick_q <= 1'b1;
      end else begin
        os_cnt_q <= os_cnt_q + 16'h0001;
      end
    end
  end

  // transmitter; ascii frames share the ten-bit length
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      UART_TXD_O <= 1'b1;
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_bit_q <= 4'h0;
      tx_os_q <= 4'h0;
    end else if (~tx_busy_q) begin
      UART_TXD_O <= 1'b1;
      if (ld) begin
        tx_sh_q <= frame(ld_byte, ascii_mode);
        tx_busy_q <= 1'b1;
        tx_bit_q <= 4'h0;
        tx_os_q <= 4'h0;
      end
    end else begin
      UART_TXD_O <= tx_sh_q[0];
      if (os_tick_q) begin
        tx_os_q <= tx_os_q + 4'h1;
        if (tx_os_q == `SPT_OS_LAST) begin
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == `SPT_FRAME_BITS - 4'h1) begin
            tx_busy_q <= 1'b0;
          end
        end
      end
    end
  end

  // receiver; pin passes two flops first
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      rx_act_q <= 1'b0;
      rx_bit_q <= 4'h0;
      rx_os_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else begin
      rxd_s1_q <= UART_RXD_I;
      rxd_s2_q <= rxd_s1_q;
      if (~rx_act_q) begin
        if (~rxd_s2_q) begin
          rx_act_q <= 1'b1;
          rx_bit_q <= 4'h0;
          rx_os_q <= 4'h0;
        end
      end else if (os_tick_q) begin
        rx_os_q <= rx_os_q + 4'h1;
        if (rx_bit_q == 4'h0 && rx_os_q == `SPT_OS_MID) begin
          // realign sample point to bit centre
          rx_os_q <= 4'h0;
          rx_bit_q <= 4'h1;
          if (rxd_s2_q) begin
            rx_act_q <= 1'b0;
          end
        end else if (rx_bit_q != 4'h0 && rx_os_q == `SPT_OS_LAST) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == `SPT_RX_STOP) begin
            rx_act_q <= 1'b0;
          end else begin
            rx_sh_q <= {rxd_s2_q, rx_sh_q[7:1]};
          end
        end
      end
    end
  end

  // ascii protocol side
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ADDR_HIT_O <= 1'b0;
      RX_DATA_O <= 8'h00;
      RX_VALID_O <= 1'b0;
    end else begin
      RX_VALID_O <= rx_good & ascii_mode;
      if (rx_good) begin
        RX_DATA_O <= rx_byte;
      end
      ADDR_HIT_O <= MSG_VALID_I & ascii_mode &
        (({MSG_GROUP_I, MSG_UNIT_I} == {group_q, unit_q}) |
         ({MSG_GROUP_I, MSG_UNIT_I} == 16'h0000));
    end
  end
endmodule

/* spt_serial_port_properties.sv */
`timescale 1ns/1ps
`include "spt_map.vh"
module spt_serial_port_props #(
  parameter CLK_HZ = 20000000
) (
  // clock and reset
  input wire CLK_SYS_I,
  input wire RST_I,
  // register bus
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [7:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire WB_ACK_O,
  // line and events
  input wire UART_TXD_O,
  input wire NVM_WE_O,
  input wire RESET_REQ_O,
  input wire [7:0] MSG_GROUP_I,
  input wire [7:0] MSG_UNIT_I,
  input wire MSG_VALID_I,
  input wire ADDR_HIT_O,
  input wire RX_VALID_O,
  input wire OPT_INIT_I,
  input wire [7:0] OPT_ADDR_O
);
  reg [2:0] mode_q;
  reg [7:0] opt_q;
  wire wr_ok = WB_ACK_O && WB_WE_I && WB_SEL_I[0];
  // shadow copies lag the design by one cycle, fine for slow events
  always @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      mode_q <= `SPT_MODE_RST;
      opt_q <= 8'h00;
    end else if (wr_ok && WB_ADR_I == `SPT_REG_MODE && WB_DAT_I[2:0] != 3'h7) begin
      mode_q <= WB_DAT_I[2:0];
    end else if (wr_ok && WB_ADR_I == `SPT_REG_OPT_ADDR) begin
      opt_q <= WB_DAT_I[7:0];
    end
  end
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ack_pulse;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  sequence s_bcast;
    MSG_VALID_I && MSG_GROUP_I == 8'h00 && MSG_UNIT_I == 8'h00 && mode_q == `SPT_MODE_ASCII;
  endsequence
  AST_ACK_ONE: assert property (s_req |=> s_ack_pulse)
    else $error("request not answered by one ack cycle");
  AST_TX_IDLE: assert property ($fell(RST_I) |-> UART_TXD_O)
    else $error("line not idle after reset");
  AST_BCAST: assert property (s_bcast |=> ADDR_HIT_O)
    else $error("broadcast address not answered");
  AST_NO_HIT: assert property (MSG_VALID_I && mode_q != `SPT_MODE_ASCII |=> !ADDR_HIT_O)
    else $error("address hit outside ascii mode");
  AST_RX_MODE: assert property (RX_VALID_O |-> mode_q == `SPT_MODE_ASCII)
    else $error("received byte outside ascii mode");
  AST_OPT_TAKE: assert property (OPT_INIT_I |=> OPT_ADDR_O == $past(opt_q))
    else $error("option address not sampled at init");
  AST_OPT_KEEP: assert property (!OPT_INIT_I |=> $stable(OPT_ADDR_O))
    else $error("option address changed without init");
  AST_RST_REQ: assert property (RESET_REQ_O |=> !RESET_REQ_O [*8])
    else $error("reset request not a single pulse");
  AST_NVM_WE: assert property (NVM_WE_O |=> !NVM_WE_O)
    else $error("nvm write strobe longer than a cycle");
endmodule
bind spt_serial_port spt_serial_port_props #(.CLK_HZ(CLK_HZ)) u_spt_serial_port_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
  .WB_ACK_O(WB_ACK_O), .UART_TXD_O(UART_TXD_O), .NVM_WE_O(NVM_WE_O),
  .RESET_REQ_O(RESET_REQ_O), .MSG_GROUP_I(MSG_GROUP_I), .MSG_UNIT_I(MSG_UNIT_I),
  .MSG_VALID_I(MSG_VALID_I), .ADDR_HIT_O(ADDR_HIT_O), .RX_VALID_O(RX_VALID_O),
  .OPT_INIT_I(OPT_INIT_I), .OPT_ADDR_O(OPT_ADDR_O)
);

/* tb_spt_serial_port.sv */
`timescale 1ns/1ps
`include "spt_map.vh"
module tb_spt_serial_port;
  // 800 khz gives div 5, so 80 clocks a bit at 9600
  localparam BIT = 80;
  reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, msg_valid = 1'b0;
  reg src_valid = 1'b0, src_last = 1'b0, nvm_busy = 1'b0, opt_init = 1'b0;
  reg [3:0] sel = 4'h0;
  reg [7:0] adr = 8'h00, src_data = 8'h00, msg_group = 8'h00, msg_unit = 8'h00;
  reg [15:0] opt_ver = 16'h0000;
  reg [31:0] dat = 32'h0, rdat, r = 32'h8ba4;
  reg [7:0] srcb [0:7];
  reg [7:0] expq [$];
  reg [23:0] nq [$];
  wire [31:0] dat_o;
  wire [15:0] nvm_addr;
  wire [7:0] nvm_data, rx_data, opt_addr;
  wire ack, rxd, txd, src_ready, src_nvm, src_active, nvm_we, reset_req, addr_hit, rx_valid;
  integer n_errors = 0, n_compared = 0, si = 0, sn = 0, n_hit = 0, n_rst = 0, n_rxv = 0;
  integer j, k, t;
  string rec = ":00000001FF\015\012";
  spt_serial_port #(.CLK_HZ(800000)) u_spt_serial_port (
    .CLK_SYS_I(clk), .RST_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .UART_RXD_I(rxd), .UART_TXD_O(txd), .SRC_DATA_I(src_data), .SRC_VALID_I(src_valid),
    .SRC_LAST_I(src_last), .SRC_READY_O(src_ready), .SRC_NVM_O(src_nvm),
    .SRC_ACTIVE_O(src_active), .NVM_BUSY_I(nvm_busy), .NVM_WE_O(nvm_we),
    .NVM_ADDR_O(nvm_addr), .NVM_DATA_O(nvm_data), .RESET_REQ_O(reset_req),
    .MSG_GROUP_I(msg_group), .MSG_UNIT_I(msg_unit), .MSG_VALID_I(msg_valid),
    .ADDR_HIT_O(addr_hit), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid),
    .OPT_INIT_I(opt_init), .OPT_VER_I(opt_ver), .OPT_ADDR_O(opt_addr)
  );
  spt_host #(.BIT(BIT)) u_spt_host (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  initial begin
    forever #25 clk = ~clk;
  end
  // byte source and event counters
  always @(posedge clk) begin
    if (src_ready) si = si + 1;
    if (nvm_we) nq.push_back({nvm_addr, nvm_data});
    // outputs are unknown until the first reset edge
    if (!rst) begin
      n_hit = n_hit + addr_hit;
      n_rst = n_rst + reset_req;
      n_rxv = n_rxv + rx_valid;
    end
    src_valid <= si < sn;
    src_last <= si == sn - 1;
    src_data <= srcb[si[2:0]];
  end
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input [31:0] e, input [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // error report writes go out with no byte lane, any write clears
  task wb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= (a == `SPT_REG_ERR) ? 4'h0 : 4'hf;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", e, rdat);
  endtask
  task st(input [2:0] e);
    wb(1'b0, `SPT_REG_STAT, 32'h0);
    chk("state", e, rdat[2:0]);
  endtask
  task msg(input [7:0] g, input [7:0] u, input [31:0] e);
    t = n_hit;
    @(posedge clk);
    msg_group <= g;
    msg_unit <= u;
    msg_valid <= 1'b1;
    @(posedge clk);
    msg_valid <= 1'b0;
    repeat (2) @(posedge clk);
    chk("address hit", e, n_hit - t);
  endtask
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(`SPT_REG_MODE, 32'h0);
    rd(`SPT_REG_BAUD, 32'h5);
    rd(`SPT_REG_GROUP, 32'h0);
    rd(`SPT_REG_UNIT, 32'h0);
    wb(1'b1, `SPT_REG_BAUD, 32'h7);
    rd(`SPT_REG_BAUD, 32'h5);
    wb(1'b1, `SPT_REG_MODE, 32'h7);
    rd(`SPT_REG_MODE, 32'h0);
    rd(8'h40, 32'h0);
    $display("registers done");
    wb(1'b1, `SPT_REG_MODE, {29'h0, `SPT_MODE_DISABLED});
    for (k = 0; k < 2; k++) begin
      expq.delete();
      u_spt_host.rxq.delete();
      for (j = 0; j < 4; j++) begin
        r = lfsr(r);
        srcb[j] = {1'b0, r[6:0]} | 8'h20;
        expq.push_back(srcb[j]);
      end
      si = 0;
      sn = 4;
      if (k == 1) for (j = 0; j < rec.len(); j++) expq.push_back(rec[j]);
      expq.push_back(`SPT_CHR_EOF);
      wb(1'b1, `SPT_REG_CTRL, 32'h1 << k);
      repeat (2) @(posedge clk);
      chk("source nvm", k, src_nvm);
      chk("source active", 1, src_active);
      u_spt_host.send(`SPT_CHR_PAUSE, 1'b0);
      repeat (20 * BIT) @(posedge clk);
      t = u_spt_host.rxq.size();
      repeat (30 * BIT) @(posedge clk);
      chk("paused count", t, u_spt_host.rxq.size());
      u_spt_host.send(`SPT_CHR_RESUME, 1'b0);
      while (u_spt_host.rxq.size() < expq.size()) @(posedge clk);
      repeat (20 * BIT) @(posedge clk);
      chk("byte count", expq.size(), u_spt_host.rxq.size());
      chk("source bytes", sn, si);
      chk("source active", 0, src_active);
      foreach (expq[j]) chk("sent byte", expq[j], u_spt_host.rxq[j]);
      $display("transfer %0d done", k);
    end
    wb(1'b1, `SPT_REG_CTRL, 32'h1 << `SPT_CTRL_RECV);
    st(3'h4);
    for (j = 0; j < 3; j++) begin
      r = lfsr(r);
      srcb[j] = {1'b0, r[6:0]} | 8'h20;
      u_spt_host.send(srcb[j], 1'b0);
    end
    nvm_busy <= 1'b1;
    u_spt_host.send(r[15:8] | 8'h20, 1'b0);
    nvm_busy <= 1'b0;
    repeat (BIT) @(posedge clk);
    rd(`SPT_REG_ERR, {16'h0, `SPT_ERR_LINE});
    wb(1'b1, `SPT_REG_ERR, r);
    rd(`SPT_REG_ERR, 32'h0);
    u_spt_host.send(`SPT_CHR_EOF, 1'b0);
    repeat (BIT) @(posedge clk);
    st(3'h5);
    chk("nvm writes", 3, nq.size());
    foreach (nq[j]) chk("nvm write", {j[15:0], srcb[j]}, nq[j]);
    wb(1'b1, `SPT_REG_CTRL, 32'h1 << `SPT_CTRL_ACK);
    repeat (3) @(posedge clk);
    chk("reset request", 1, n_rst);
    st(3'h0);
    $display("receive done");
    r = lfsr(r);
    wb(1'b1, `SPT_REG_GROUP, {24'h0, r[7:0] | 8'h01});
    wb(1'b1, `SPT_REG_UNIT, {24'h0, r[15:8]});
    wb(1'b1, `SPT_REG_MODE, {29'h0, `SPT_MODE_ASCII});
    wb(1'b1, `SPT_REG_CTRL, 32'h1);
    st(3'h0);
    msg(r[7:0] | 8'h01, r[15:8], 1);
    msg(8'h00, 8'h00, 1);
    msg(r[7:0] | 8'h01, r[15:8] ^ 8'h01, 0);
    u_spt_host.send({1'b0, r[22:16]}, 1'b1);
    repeat (BIT) @(posedge clk);
    chk("rx data", {1'b0, r[22:16]}, rx_data);
    chk("rx count", 1, n_rxv);
    $display("ascii done");
    wb(1'b1, `SPT_REG_OPT_ADDR, {24'h0, r[31:24]});
    @(posedge clk);
    opt_ver <= r[15:0] | 16'h0001;
    opt_init <= 1'b1;
    @(posedge clk);
    opt_init <= 1'b0;
    wb(1'b1, `SPT_REG_OPT_ADDR, {24'h0, ~r[31:24]});
    wb(1'b1, `SPT_REG_MODE, {29'h0, `SPT_MODE_FIELDBUS});
    rd(`SPT_REG_OPT_LIVE, {r[15:0] | 16'h0001, 8'h0, r[31:24]});
    chk("option address", r[31:24], opt_addr);
    wb(1'b1, `SPT_REG_MODE, {29'h0, `SPT_MODE_DISABLED});
    rd(`SPT_REG_OPT_LIVE, 32'h0);
    msg(8'h00, 8'h00, 0);
    $display("option done");
    complete_run;
  end
  initial begin
    repeat (80000) @(posedge clk);
    n_errors = n_errors + 1;
    $display("wrong value run time expected finish seen timeout");
    complete_run;
  end
endmodule
